// File: deser_cfg_regs.svh
// register offsets, field positions, reset values and timing counts for the
// deserializer id, reset and clock-output configuration bank
// assumes an 8-bit register pointer and an I2C target path clocked by ref_clk
// Function
// - The 7-bit target address sits in bits 7:1 of the address register and resets to 0x60.
// - Select bit zero answers at the strap address, select bit one at the programmed address.
// - Analog power-down is set only by a local I2C write of one; writing zero does nothing.
// - A one in the keep-registers reset bit resets logic but not registers, then self-clears.
// - A one in the full reset bit resets all logic but the I2C engine, and the registers, then self-clears.
// - Oscillator clock is output only with auto-clock set and no lock, else the pixel clock.
`ifndef DESER_CFG_REGS_SVH
`define DESER_CFG_REGS_SVH

`define OFS_TARGET_ADDRESS  8'h00
`define OFS_POWER_RESET     8'h01
`define OFS_CLOCK_OUT_CFG   8'h04

`define BIT_ADDR_SELECT     0
`define BIT_ANALOG_PWDN     5
`define BIT_RESET_KEEP      1
`define BIT_RESET_FULL      0
`define BIT_AUTO_CLOCK      5

`define RST_TARGET_ADDRESS  7'h60
`define RST_ADDR_SELECT     1'h0
`define RST_AUTO_CLOCK      1'h0

// length of a soft reset pulse, ns, and its cycle count at 20 ns per cycle
`define SOFT_RESET_NS       320
`define CLK_PERIOD_NS       20
`define SOFT_RESET_CYCLES   ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: deser_cfg_pkg.sv
// types shared by the configuration bank
// assumes nothing of its surroundings
package deser_cfg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_PTR,
    ST_ACK_PTR,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_RACK
  } i2c_state_t;
endpackage

// File: pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level; multi-bit values must be static
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // pins and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // refuse an empty group at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      // first stage feeds only the second stage; each bit keeps its own flops
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1 <= 1'h0;
          stage2 <= 1'h0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate
endmodule

// File: deser_id_reset_config_regs.sv
// I2C target and configuration bank: target address, analog power-down,
// two self-clearing soft resets and the clock-output source choice
// assumes scl/sda, strap and lock are asynchronous pins; remote writes from the
// back channel arrive on ref_clk; sda is open drain, resolved outside
`timescale 1ns/1ps
`include "deser_cfg_regs.svh"
module deser_id_reset_config_regs #(
  parameter int RESET_CYCLES = `SOFT_RESET_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // local I2C bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address strap
  input  wire logic [6:0] strap_address_value,
  // writes arriving over the control channel from the far end
  input  wire logic       remote_wr_en,
  input  wire logic [7:0] remote_addr,
  input  wire logic [7:0] remote_wdata,
  // clock output
  input  wire logic       pixel_clock,
  input  wire logic       internal_oscillator_clock,
  input  wire logic       link_locked,
  output logic            clock_out,
  // power and reset controls
  output logic            analog_power_down,
  output logic            digital_reset
);
  // the pulse counter is eight bits wide, so longer pulses are refused
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_bad_cycles
    $error("RESET_CYCLES out of range");
  end

  // synchronised pins
  logic       scl_s;
  logic       sda_s;
  logic       lock_s;
  logic [6:0] strap_s;

  pin_sync #(.WIDTH(10)) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in ({scl_in, sda_in, link_locked, strap_address_value}),
    .sync_out ({scl_s, sda_s, lock_s, strap_s})
  );

  // register state
  logic [6:0] target_address;
  logic       addr_select;
  logic       auto_clock;
  logic       keep_busy;
  logic       full_busy;
  logic [7:0] reset_count;

  // i2c engine state
  deser_cfg_pkg::i2c_state_t state;
  logic       scl_d;
  logic       sda_d;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [3:0] bit_cnt;
  logic [7:0] ptr;
  logic       read_mode;
  logic       local_wr;
  logic [7:0] local_addr;
  logic [7:0] local_wdata;

  // bus events from the delayed synchronised lines
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] active_address;

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign active_address = addr_select ? target_address : strap_s;
  assign sda_out = 1'h0;

  // merged write port; a local access wins when both arrive together
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  assign wr_en   = local_wr | remote_wr_en;
  assign wr_addr = local_wr ? local_addr : remote_addr;
  assign wr_data = local_wr ? local_wdata : remote_wdata;

  // read mux; busy reset bits read one until the pulse is over
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr)
      `OFS_TARGET_ADDRESS: rd_byte = {target_address, addr_select};
      `OFS_POWER_RESET: begin
        rd_byte[`BIT_ANALOG_PWDN] = analog_power_down;
        rd_byte[`BIT_RESET_KEEP]  = keep_busy;
        rd_byte[`BIT_RESET_FULL]  = full_busy;
      end
      `OFS_CLOCK_OUT_CFG: rd_byte[`BIT_AUTO_CLOCK] = auto_clock;
      default: rd_byte = 8'h00;
    endcase
  end

  // line history for edge and start/stop detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // i2c target engine; soft resets leave it alone so the ack of the write
  // that triggered them still completes on the bus
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= deser_cfg_pkg::ST_IDLE;
      shreg       <= 8'h00;
      txreg       <= 8'h00;
      bit_cnt     <= 4'h0;
      ptr         <= 8'h00;
      read_mode   <= 1'h0;
      sda_oe      <= 1'h0;
      local_wr    <= 1'h0;
      local_addr  <= 8'h00;
      local_wdata <= 8'h00;
    end else begin
      local_wr <= 1'h0;
      if (stop_cond) begin
        state  <= deser_cfg_pkg::ST_IDLE;
        sda_oe <= 1'h0;
      end else if (start_cond) begin
        state   <= deser_cfg_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'h0;
      end else if (scl_rise) begin
        unique case (state)
          deser_cfg_pkg::ST_ADDR, deser_cfg_pkg::ST_PTR, deser_cfg_pkg::ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          deser_cfg_pkg::ST_RDATA: bit_cnt <= bit_cnt + 4'h1;
          deser_cfg_pkg::ST_RACK: if (sda_s) state <= deser_cfg_pkg::ST_IDLE; // host nack
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state)
          deser_cfg_pkg::ST_ADDR: if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == active_address) begin
              state     <= deser_cfg_pkg::ST_ACK_ADDR;
              read_mode <= shreg[0];
              sda_oe    <= 1'h1;
            end else begin
              state <= deser_cfg_pkg::ST_IDLE;
            end
          end
          deser_cfg_pkg::ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              state  <= deser_cfg_pkg::ST_RDATA;
              txreg  <= {rd_byte[6:0], 1'h0};
              sda_oe <= ~rd_byte[7];
            end else begin
              state  <= deser_cfg_pkg::ST_PTR;
              sda_oe <= 1'h0;
            end
          end
          deser_cfg_pkg::ST_PTR: if (bit_cnt == 4'h8) begin
            ptr    <= shreg;
            state  <= deser_cfg_pkg::ST_ACK_PTR;
            sda_oe <= 1'h1;
          end
          deser_cfg_pkg::ST_ACK_PTR, deser_cfg_pkg::ST_ACK_WDATA: begin
            state   <= deser_cfg_pkg::ST_WDATA;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'h0;
          end
          deser_cfg_pkg::ST_WDATA: if (bit_cnt == 4'h8) begin
            local_wr    <= 1'h1;
            local_addr  <= ptr;
            local_wdata <= shreg;
            ptr         <= ptr + 8'h01;
            state       <= deser_cfg_pkg::ST_ACK_WDATA;
            sda_oe      <= 1'h1;
          end
          deser_cfg_pkg::ST_RDATA: begin
            if (bit_cnt == 4'h8) begin
              state  <= deser_cfg_pkg::ST_RACK;
              ptr    <= ptr + 8'h01;
              sda_oe <= 1'h0;
            end else begin
              txreg  <= {txreg[6:0], 1'h0};
              sda_oe <= ~txreg[7];
            end
          end
          deser_cfg_pkg::ST_RACK: begin
            state   <= deser_cfg_pkg::ST_RDATA;
            bit_cnt <= 4'h0;
            txreg   <= {rd_byte[6:0], 1'h0};
            sda_oe  <= ~rd_byte[7];
          end
          default: ;
        endcase
      end
    end
  end

  // configuration registers; a full soft reset holds them at their defaults
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      target_address <= `RST_TARGET_ADDRESS;
      addr_select    <= `RST_ADDR_SELECT;
      auto_clock     <= `RST_AUTO_CLOCK;
    end else if (full_busy) begin
      target_address <= `RST_TARGET_ADDRESS;
      addr_select    <= `RST_ADDR_SELECT;
      auto_clock     <= `RST_AUTO_CLOCK;
    end else if (wr_en && wr_addr == `OFS_TARGET_ADDRESS) begin
      target_address <= wr_data[7:1];
      addr_select    <= wr_data[`BIT_ADDR_SELECT];
    end else if (wr_en && wr_addr == `OFS_CLOCK_OUT_CFG) begin
      auto_clock <= wr_data[`BIT_AUTO_CLOCK];
    end
  end

  // power-down is set only from the local bus; zero writes and remote writes
  // are ignored, so only a full reset or power-on clears it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_power_down <= 1'h0;
    end else if (full_busy) begin
      analog_power_down <= 1'h0;
    end else if (local_wr && local_addr == `OFS_POWER_RESET
                 && local_wdata[`BIT_ANALOG_PWDN]) begin
      analog_power_down <= 1'h1;
    end
  end

  // soft reset pulse timer; writing one starts it, writing zero does nothing,
  // the bit drops back to zero when the pulse ends
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      keep_busy   <= 1'h0;
      full_busy   <= 1'h0;
      reset_count <= 8'h00;
    end else if (keep_busy || full_busy) begin
      if (reset_count == 8'h01) begin
        keep_busy <= 1'h0;
        full_busy <= 1'h0;
      end
      reset_count <= reset_count - 8'h01;
    end else if (wr_en && wr_addr == `OFS_POWER_RESET
                 && (wr_data[`BIT_RESET_FULL] || wr_data[`BIT_RESET_KEEP])) begin
      full_busy   <= wr_data[`BIT_RESET_FULL];
      keep_busy   <= ~wr_data[`BIT_RESET_FULL];
      reset_count <= RESET_CYCLES[7:0];
    end
  end

  // reset to the rest of the digital logic, high for the whole pulse
  assign digital_reset = keep_busy | full_busy;

  // clock-output source; the select moves on a lock change, an auto-clock write or a full reset, a short
  // runt pulse is possible then since this is a plain mux, not a glitch-free one
  logic use_osc;
  assign use_osc   = auto_clock & ~lock_s;
  assign clock_out = use_osc ? internal_oscillator_clock : pixel_clock;
endmodule

// File: deser_cfg_props.sv
// port checker for the id, reset and clock-output configuration bank
// assumes it is bound into deser_id_reset_config_regs
`timescale 1ns/1ps
module deser_cfg_props #(
  parameter int RESET_CYCLES = 16
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // local bus
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // control channel writes
  input wire logic       remote_wr_en,
  input wire logic [7:0] remote_addr,
  input wire logic [7:0] remote_wdata,
  // clock output and controls
  input wire logic       pixel_clock,
  input wire logic       link_locked,
  input wire logic       clock_out,
  input wire logic       analog_power_down,
  input wire logic       digital_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [8:0] hi_cnt;
  logic       rst_wr;
  // length of the running soft reset pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) hi_cnt <= 9'h000;
    else hi_cnt <= digital_reset ? hi_cnt + 9'h001 : 9'h000;
  end
  assign rst_wr = remote_wr_en && remote_addr == 8'h01 && !digital_reset;
  full_reset_a: assert property (rst_wr && remote_wdata[0] |=> digital_reset)
    else $error("full reset bit did not start a pulse");
  keep_reset_a: assert property (rst_wr && remote_wdata[1] |=> digital_reset)
    else $error("keep reset bit did not start a pulse");
  pulse_len_a: assert property ($fell(digital_reset) |-> hi_cnt == RESET_CYCLES)
    else $error("soft reset pulse has wrong length");
  pulse_cap_a: assert property (hi_cnt <= RESET_CYCLES)
    else $error("soft reset pulse does not clear itself");
  pwdn_remote_a: assert property (
    remote_wr_en && !analog_power_down |=> !analog_power_down)
    else $error("remote write set the power-down bit");
  pwdn_hold_a: assert property (
    $fell(analog_power_down) |-> digital_reset || $past(digital_reset))
    else $error("power-down cleared without a full reset");
  // the lock pin reaches the mux select two edges after it is sampled
  lock_mux_a: assert property (
    $past(link_locked, 2) |-> clock_out == pixel_clock)
    else $error("locked link must output the pixel clock");
  ack_edge_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("acknowledge started while clock high");
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
endmodule
bind deser_id_reset_config_regs deser_cfg_props #(.RESET_CYCLES(RESET_CYCLES)) props_u (
  .ref_clk, .arst_n, .scl_in, .sda_out, .sda_oe, .remote_wr_en, .remote_addr,
  .remote_wdata, .pixel_clock, .link_locked, .clock_out, .analog_power_down, .digital_reset);

// File: i2c_host.sv
// host model for the local I2C bus, paced by ref_clk
// assumes sda_line is the wired-and of all drivers with a pull-up
`timescale 1ns/1ps
module i2c_host (
  // pacing clock
  input  wire logic ref_clk,
  // bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // each clock phase kept well above the six-cycle minimum
  localparam int HALF = 8;
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic hw(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_drv <= 1'h1;
    hw(HALF);
    scl <= 1'h1;
    hw(HALF);
    sda_drv <= 1'h0;
    hw(HALF);
    scl <= 1'h0;
    hw(2);
  endtask
  task automatic stop();
    sda_drv <= 1'h0;
    hw(HALF);
    scl <= 1'h1;
    hw(HALF);
    sda_drv <= 1'h1;
    hw(HALF);
  endtask
  // data moves only while clock is low, two cycles after the fall
  task automatic bitx(input logic b, output logic r);
    sda_drv <= b;
    hw(HALF);
    scl <= 1'h1;
    hw(4);
    r = sda_line;
    hw(4);
    scl <= 1'h0;
    hw(2);
  endtask
  // only this host may set power-down, through an ordinary write
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'h1, r);
    ack = ~r;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'h1, d[i]);
    bitx(1'h1, r); // nack ends the read
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the configuration bank
// assumes the host model drives the local bus; sda has a pull-up
`timescale 1ns/1ps
module testbench;
  localparam int RC = 2;
  logic       ref_clk, arst_n, scl_in, sda_drv, sda_line, sda_out, sda_oe;
  logic [6:0] strap_address_value;
  logic       remote_wr_en, pixel_clock, internal_oscillator_clock, link_locked;
  logic [7:0] remote_addr, remote_wdata, obs;
  logic       clock_out, analog_power_down, digital_reset;
  int         fails = 0, tests_run = 0, hi_n = 0, last_len = 0;
  logic [7:0] exp_q[$];
  event       result_ev;
  assign sda_line = sda_drv & ~sda_oe;
  deser_id_reset_config_regs #(.RESET_CYCLES(RC)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_address_value(strap_address_value),
    .remote_wr_en(remote_wr_en), .remote_addr(remote_addr), .remote_wdata(remote_wdata),
    .pixel_clock(pixel_clock), .internal_oscillator_clock(internal_oscillator_clock),
    .link_locked(link_locked), .clock_out(clock_out),
    .analog_power_down(analog_power_down), .digital_reset(digital_reset));
  i2c_host host_u (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl_in), .sda_drv(sda_drv));
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic post(logic [7:0] s, logic [7:0] e);
    exp_q.push_back(e);
    obs = s;
    ->result_ev;
    #1;
  endtask
  // monitor side: oldest note against each result
  initial forever begin
    @(result_ev);
    check(obs, exp_q.pop_front());
  end
  // free-running sources; measured soft reset pulse length
  always @(posedge ref_clk) begin
    pixel_clock <= 1'($urandom);
    internal_oscillator_clock <= 1'($urandom);
    if (digital_reset === 1'h1) hi_n++;
    else if (hi_n != 0) begin
      last_len = hi_n;
      hi_n = 0;
    end
  end
  task automatic remote(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    remote_wr_en <= 1'h1;
    remote_addr <= a;
    remote_wdata <= d;
    @(posedge ref_clk);
    remote_wr_en <= 1'h0;
    repeat (RC + 6) @(posedge ref_clk);
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] r, logic [7:0] d, output logic k);
    logic x;
    host_u.start();
    host_u.wbyte({a, 1'h0}, k);
    if (k) begin
      host_u.wbyte(r, x);
      host_u.wbyte(d, x);
    end
    host_u.stop();
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] r, logic [7:0] e);
    logic x;
    logic [7:0] d;
    host_u.start();
    host_u.wbyte({a, 1'h0}, x);
    host_u.wbyte(r, x);
    host_u.start();
    host_u.wbyte({a, 1'h1}, x);
    host_u.rbyte(d);
    host_u.stop();
    post(d, e);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    final_report();
  end
  initial begin
    logic       k;
    logic [6:0] na;
    logic       ck;
    void'($urandom(32'hE1BB));
    arst_n = 1'h0;
    remote_wr_en = 1'h0;
    remote_addr = 8'h00;
    remote_wdata = 8'h00;
    link_locked = 1'h1;
    do strap_address_value = 7'($urandom); while (strap_address_value == 7'h60);
    do na = 7'($urandom); while (na == strap_address_value || na == 7'h60);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    rd(strap_address_value, 8'h00, 8'hC0);
    wr(7'h60, 8'h00, 8'h00, k);
    post({7'h00, k}, 8'h00);
    wr(strap_address_value, 8'h00, {na, 1'h1}, k);
    wr(strap_address_value, 8'h3C, 8'h00, k);
    post({7'h00, k}, 8'h00);
    rd(na, 8'h00, {na, 1'h1});
    last_len = 0;
    remote(8'h01, 8'h01);
    post(8'(last_len), 8'(RC));
    rd(strap_address_value, 8'h00, 8'hC0);
    rd(strap_address_value, 8'h01, 8'h00);
    rd(strap_address_value, 8'h3C, 8'h00);
    remote(8'h01, 8'h20);
    post({7'h00, analog_power_down}, 8'h00);
    wr(strap_address_value, 8'h01, 8'h20, k);
    wr(strap_address_value, 8'h01, 8'h00, k);
    post({7'h00, analog_power_down}, 8'h01);
    wr(strap_address_value, 8'h00, {na, 1'h1}, k);
    last_len = 0;
    wr(na, 8'h01, 8'h22, k);
    post(8'(last_len), 8'(RC));
    rd(na, 8'h00, {na, 1'h1});
    rd(na, 8'h01, 8'h20);
    remote(8'h01, 8'h01);
    post({7'h00, analog_power_down}, 8'h00);
    // auto-clock unlocked, auto-clock locked, pixel only unlocked
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      link_locked <= 1'(i == 1);
      remote(8'h04, (i == 2) ? 8'h00 : 8'h20);
      if (i == 0) rd(strap_address_value, 8'h04, 8'h20);
      repeat (8) begin
        @(negedge ref_clk);
        ck = (i == 0) ? internal_oscillator_clock : pixel_clock;
        post({7'h00, clock_out}, {7'h00, ck});
      end
    end
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule
